// >>> ts_core.sv
// Purpose: Command-indexed register bank and conversion control
// Assumes: Protocol engine and front end run on clk_sys_in
// Notes: Temperatures arrive as signed eighths of a degree
// Notes on behaviour
// - Read map: status, setup, rate, four limits
// - Write indices update setup, rate, limits, trigger
// - Fraction bytes at 10h and 11h, reset zero
// - Reset: rate 02h, upper 7Fh, lower C9h
// - Fixed identity and revision codes readable
// - Setup bit 7 suppresses the alert output
// - Setup bit 6 or a low standby pin selects standby, else autoconvert
// - Setup bit 5 extends low range to -64
// - Setup bit 4 cancellation; low bits reset zero
// - Fraction and cancellation only at 1Hz or slower
// - Status bit 7 shows conversion busy
// - Status alarm and open flags; low bits zero
// - Status read clears flags whose cause ended
// - Status read also releases alert latch if cause ended
// - Register reads never collide with result updates
// - Only rate bits 2 to 0 are decoded
// - Rate codes double frequency from 0.0625 Hz
// - Results valid one conversion after any start
// - Slave address decoded from two three-state straps
// - Straps sampled once after reset, then held
// - Power-up clears alert, index zero, autoconverts
// - One-shot ignored when busy; restarts rate timer
// - Alarm when temperature reaches a threshold
// - Open diode loads 80h and sets flag
// - Alert response clears latch if cause ended
`timescale 1ns/1ps
`include "ts_consts.svh"
module ts_core #(
	parameter logic [31:0] BASE_PERIOD_CYC = 32'(`TS_BASE_PERIOD_CYC),
	parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary value
	parameter logic [7:0] PART_REV = 8'h01 // Arbitrary value
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_has_data_in,
	input wire logic [7:0] cmd_index_in,
	input wire logic [7:0] cmd_data_in,
	input wire logic rd_req_in,
	input wire logic ara_req_in,
	input wire logic [1:0] address_strap_a_in,
	input wire logic [1:0] address_strap_b_in,
	input wire logic standby_pin_n_in,
	input wire logic conv_done_in,
	input wire logic [10:0] local_temp_in,
	input wire logic [10:0] remote_temp_in,
	input wire logic remote_open_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output logic [7:0] ara_data_out,
	output logic ara_valid_out,
	output logic [6:0] slave_addr_out,
	output logic alert_o_out,
	output logic alert_oe_n_out,
	output logic conv_start_out,
	output logic conv_rcancel_out,
	output logic conv_extended_out
);
	logic [7:0] index_reg;
	logic [7:0] setup_reg;
	logic [7:0] rate_reg;
	logic [7:0] lhi_reg;
	logic [7:0] llo_reg;
	logic [7:0] rhi_reg;
	logic [7:0] rlo_reg;
	logic [7:0] ltemp_reg;
	logic [7:0] rtemp_reg;
	logic [7:0] lfrac_reg;
	logic [7:0] rfrac_reg;
	logic [7:0] lfrac_snap_reg;
	logic [7:0] rfrac_snap_reg;
	logic [4:0] flags_reg;
	logic [4:0] cond_reg;
	logic alert_reg;
	logic strap_done_reg;
	logic standby_pin_meta_reg;
	logic standby_pin_sync_reg;
	logic [1:0] strap_a_meta_reg;
	logic [1:0] strap_a_sync_reg;
	logic [1:0] strap_b_meta_reg;
	logic [1:0] strap_b_sync_reg;
	logic [31:0] timer_reg;
	logic start_pend_reg;
	ts_pkg::ts_state_t state_reg;
	logic wr_hit;
	logic one_shot;
	logic standby;
	logic ext_mode;
	logic auto_start;
	logic do_start;
	logic status_rd;
	logic [31:0] period;
	logic [10:0] lclamp;
	logic [10:0] rclamp;
	logic [4:0] cond_now;
	logic [7:0] status_val;

	// Two strap codes to the seven-bit slave address
	function automatic logic [6:0] strap_dec(input logic [1:0] a, input logic [1:0] b);
		logic [3:0] hi;
		logic [2:0] lo_a;
		logic [2:0] lo_b;
		hi = 4'h3;
		lo_a = 3'h0;
		lo_b = 3'h0;
		// Strap a picks the upper group and a low offset of 0, 1 or 4
		unique case (a)
			ts_pkg::TS_STRAP_LOW: begin
				hi = 4'h3;
				lo_a = 3'h0;
			end
			ts_pkg::TS_STRAP_OPEN: begin
				hi = 4'h5;
				lo_a = 3'h1;
			end
			default: begin
				hi = 4'h9;
				lo_a = 3'h4;
			end
		endcase
		// Strap b adds 0, 1 or 2
		unique case (b)
			ts_pkg::TS_STRAP_LOW: lo_b = 3'h0;
			ts_pkg::TS_STRAP_OPEN: lo_b = 3'h1;
			default: lo_b = 3'h2;
		endcase
		return {hi, 3'(lo_a + lo_b)};
	endfunction : strap_dec

	// Clamp a reading to the reportable low end
	function automatic logic [10:0] clamp_low(input logic [10:0] t, input logic ext);
		logic [10:0] lim;
		lim = ext ? `TS_EXT_LOW_MIN : 11'h000;
		return ($signed(t) < $signed(lim)) ? lim : t;
	endfunction : clamp_low

	// Register read mux
	function automatic logic [7:0] rd_mux(input logic [7:0] idx, input logic [7:0] st);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			`TS_IDX_LOCAL_TEMP: v = ltemp_reg;
			`TS_IDX_REMOTE_TEMP: v = rtemp_reg;
			`TS_IDX_STATUS: v = st;
			`TS_IDX_SETUP_RD: v = setup_reg;
			`TS_IDX_RATE_RD: v = rate_reg;
			`TS_IDX_LHI_RD: v = lhi_reg;
			`TS_IDX_LLO_RD: v = llo_reg;
			`TS_IDX_RHI_RD: v = rhi_reg;
			`TS_IDX_RLO_RD: v = rlo_reg;
			`TS_IDX_REMOTE_FRAC: v = rfrac_snap_reg;
			`TS_IDX_LOCAL_FRAC: v = lfrac_snap_reg;
			`TS_IDX_PART_ID: v = PART_ID;
			`TS_IDX_PART_REV: v = PART_REV;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : rd_mux

	// Write decode and mode terms
	assign wr_hit = cmd_valid_in & cmd_has_data_in;
	assign one_shot = cmd_valid_in & (cmd_index_in == `TS_IDX_ONE_SHOT);
	// Standby from setup bit or pin
	assign standby = setup_reg[`TS_SETUP_STANDBY] | ~standby_pin_sync_reg;
	// Extended mode at 1 Hz or slower
	assign ext_mode = (rate_reg[2:0] <= `TS_RATE_EXT_MAX);
	assign period = BASE_PERIOD_CYC >> rate_reg[2:0];
	assign auto_start = ~standby & (start_pend_reg | (timer_reg >= period));
	// Start only when no conversion runs
	assign do_start = (state_reg == ts_pkg::TS_ST_IDLE) & (one_shot | auto_start);
	assign status_rd = rd_req_in & (index_reg == `TS_IDX_STATUS);
	// Clamp readings to the low range
	assign lclamp = clamp_low(local_temp_in, setup_reg[`TS_SETUP_EXT_LOW]);
	assign rclamp = clamp_low(remote_temp_in, setup_reg[`TS_SETUP_EXT_LOW]);
	// Alarm conditions of the new results
	assign cond_now[4] = $signed(lclamp[10:3]) >= $signed(lhi_reg);
	assign cond_now[3] = $signed(lclamp[10:3]) <= $signed(llo_reg);
	assign cond_now[2] = ~remote_open_in & ($signed(rclamp[10:3]) >= $signed(rhi_reg));
	assign cond_now[1] = ~remote_open_in & ($signed(rclamp[10:3]) <= $signed(rlo_reg));
	assign cond_now[0] = remote_open_in;
	assign status_val = {(state_reg == ts_pkg::TS_ST_CONV), flags_reg, 2'b00};

	// Standby pin synchroniser
	always_ff @(posedge clk_sys_in) begin
		standby_pin_meta_reg <= standby_pin_n_in;
		standby_pin_sync_reg <= standby_pin_meta_reg;
	end

	// Strap pad synchronisers, settled well before reset ends
	always_ff @(posedge clk_sys_in) begin
		strap_a_meta_reg <= address_strap_a_in;
		strap_a_sync_reg <= strap_a_meta_reg;
		strap_b_meta_reg <= address_strap_b_in;
		strap_b_sync_reg <= strap_b_meta_reg;
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			strap_done_reg <= 1'b0;
			slave_addr_out <= 7'h00;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			slave_addr_out <= strap_dec(strap_a_sync_reg, strap_b_sync_reg);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			index_reg <= `TS_RST_INDEX;
		end else if (cmd_valid_in) begin
			index_reg <= cmd_index_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			setup_reg <= `TS_RST_SETUP;
			rate_reg <= `TS_RST_RATE;
			lhi_reg <= `TS_RST_UPPER;
			llo_reg <= `TS_RST_LOWER;
			rhi_reg <= `TS_RST_UPPER;
			rlo_reg <= `TS_RST_LOWER;
		end else if (wr_hit) begin
			unique case (cmd_index_in)
				`TS_IDX_SETUP_WR: setup_reg <= {cmd_data_in[7:3], 3'b000};
				`TS_IDX_RATE_WR: rate_reg <= cmd_data_in;
				`TS_IDX_LHI_WR: lhi_reg <= cmd_data_in;
				`TS_IDX_LLO_WR: llo_reg <= cmd_data_in;
				`TS_IDX_RHI_WR: rhi_reg <= cmd_data_in;
				`TS_IDX_RLO_WR: rlo_reg <= cmd_data_in;
				default: ;
			endcase
		end
	end

	// Conversion state, first start right after reset
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			state_reg <= ts_pkg::TS_ST_IDLE;
			start_pend_reg <= 1'b1;
			conv_start_out <= 1'b0;
		end else begin
			conv_start_out <= do_start;
			unique case (state_reg)
				ts_pkg::TS_ST_IDLE: begin
					if (do_start) begin
						state_reg <= ts_pkg::TS_ST_CONV;
						start_pend_reg <= 1'b0;
					end
				end
				ts_pkg::TS_ST_CONV: begin
					if (conv_done_in) begin
						state_reg <= ts_pkg::TS_ST_IDLE;
					end
					if (timer_reg >= period) begin
						start_pend_reg <= 1'b1;
					end
				end
			endcase
		end
	end

	// Rate timer restarts on every start
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			timer_reg <= 32'h0000_0000;
		end else if (do_start) begin
			timer_reg <= 32'h0000_0001;
		end else if (timer_reg < period) begin
			timer_reg <= timer_reg + 32'h0000_0001;
		end
	end

	// Mode levels to the front end
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			conv_rcancel_out <= 1'b0;
			conv_extended_out <= 1'b0;
		end else begin
			conv_rcancel_out <= setup_reg[`TS_SETUP_RCANCEL] & ext_mode;
			conv_extended_out <= ext_mode;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			ltemp_reg <= `TS_RST_TEMP;
			rtemp_reg <= `TS_RST_TEMP;
			lfrac_reg <= `TS_RST_TEMP;
			rfrac_reg <= `TS_RST_TEMP;
			cond_reg <= 5'h00;
		end else if (conv_done_in && state_reg == ts_pkg::TS_ST_CONV) begin
			ltemp_reg <= lclamp[10:3];
			lfrac_reg <= ext_mode ? {lclamp[2:0], 5'h00} : 8'h00;
			rtemp_reg <= remote_open_in ? `TS_OPEN_TEMP : rclamp[10:3];
			rfrac_reg <= (ext_mode && !remote_open_in) ? {rclamp[2:0], 5'h00} : 8'h00;
			cond_reg <= cond_now;
		end
	end

	// Fraction snapshot taken with the main byte
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			lfrac_snap_reg <= `TS_RST_TEMP;
			rfrac_snap_reg <= `TS_RST_TEMP;
		end else if (rd_req_in) begin
			if (index_reg == `TS_IDX_LOCAL_TEMP) begin
				lfrac_snap_reg <= lfrac_reg;
			end
			if (index_reg == `TS_IDX_REMOTE_TEMP) begin
				rfrac_snap_reg <= rfrac_reg;
			end
		end
	end

	// Sticky flags, set wins over clear
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			flags_reg <= 5'h00;
		end else begin
			flags_reg <= (status_rd ? (flags_reg & cond_reg) : flags_reg) |
				((conv_done_in && state_reg == ts_pkg::TS_ST_CONV) ? cond_now : 5'h00);
		end
	end

	// Alert latch clears only once cause ended
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			alert_reg <= 1'b0;
		end else if (conv_done_in && state_reg == ts_pkg::TS_ST_CONV && |cond_now) begin
			alert_reg <= 1'b1;
		end else if ((status_rd || (ara_req_in && alert_reg)) && !(|cond_reg)) begin
			alert_reg <= 1'b0;
		end
	end

	// Open-drain alert, suppressed by setup bit 7
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			alert_o_out <= 1'b0;
			alert_oe_n_out <= 1'b1;
		end else begin
			alert_o_out <= 1'b0;
			alert_oe_n_out <= ~(alert_reg & ~setup_reg[`TS_SETUP_ALERT_SUPPRESS]);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rd_data_out <= 8'h00;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= rd_req_in;
			if (rd_req_in) begin
				rd_data_out <= rd_mux(index_reg, status_val);
			end
		end
	end

	// Alert response returns address and one
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			ara_data_out <= 8'h00;
			ara_valid_out <= 1'b0;
		end else begin
			ara_valid_out <= ara_req_in & alert_reg;
			if (ara_req_in) begin
				ara_data_out <= {slave_addr_out, 1'b1};
			end
		end
	end
endmodule : ts_core

// >>> ts_consts.svh
// Purpose: Constant values of the dual temperature sensor register core
// Assumes: 250 MHz core clock
// Notes: Indices are command-byte values
`ifndef TS_CONSTS_SVH
`define TS_CONSTS_SVH
// Read indices
`define TS_IDX_LOCAL_TEMP 8'h00
`define TS_IDX_REMOTE_TEMP 8'h01
`define TS_IDX_STATUS 8'h02
`define TS_IDX_SETUP_RD 8'h03
`define TS_IDX_RATE_RD 8'h04
`define TS_IDX_LHI_RD 8'h05
`define TS_IDX_LLO_RD 8'h06
`define TS_IDX_RHI_RD 8'h07
`define TS_IDX_RLO_RD 8'h08
// Write indices, then fraction and identity read indices
`define TS_IDX_SETUP_WR 8'h09
`define TS_IDX_RATE_WR 8'h0A
`define TS_IDX_LHI_WR 8'h0B
`define TS_IDX_LLO_WR 8'h0C
`define TS_IDX_RHI_WR 8'h0D
`define TS_IDX_RLO_WR 8'h0E
`define TS_IDX_ONE_SHOT 8'h0F
`define TS_IDX_REMOTE_FRAC 8'h10
`define TS_IDX_LOCAL_FRAC 8'h11
`define TS_IDX_PART_ID 8'hFE
`define TS_IDX_PART_REV 8'hFF
// Reset values and open-diode reading
`define TS_RST_INDEX 8'h00
`define TS_RST_SETUP 8'h00
`define TS_RST_RATE 8'h02
`define TS_RST_UPPER 8'h7F
`define TS_RST_LOWER 8'hC9
`define TS_RST_TEMP 8'h00
`define TS_OPEN_TEMP 8'h80
// Setup bit positions
`define TS_SETUP_ALERT_SUPPRESS 7
`define TS_SETUP_STANDBY 6
`define TS_SETUP_EXT_LOW 5
`define TS_SETUP_RCANCEL 4
`define TS_SETUP_JUNCTION 3
// Status bit positions
`define TS_STAT_BUSY 7
`define TS_STAT_LOCAL_OVER 6
`define TS_STAT_LOCAL_UNDER 5
`define TS_STAT_REMOTE_OVER 4
`define TS_STAT_REMOTE_UNDER 3
`define TS_STAT_OPEN 2
// Fastest rate code giving extended mode (1 Hz)
`define TS_RATE_EXT_MAX 3'h4
// Extended low limit, in eighths of a degree (-64 C)
`define TS_EXT_LOW_MIN 11'h600
// Timing: period at rate code 0 (0.0625 Hz) and clock rate
`define TS_BASE_PERIOD_MS 16000
`define TS_CLK_KHZ 250000
`define TS_BASE_PERIOD_CYC (64'd`TS_BASE_PERIOD_MS * 64'd`TS_CLK_KHZ)
`endif

// >>> ts_pkg.sv
// Purpose: Types of the dual temperature sensor register core
// Assumes: Used through ts_pkg:: scoping only
// Notes: Strap codes come from the three-state pad detector
package ts_pkg;
	// Conversion control states, Gray coded
	typedef enum logic [1:0] {
		TS_ST_IDLE = 2'b00,
		TS_ST_CONV = 2'b01
	} ts_state_t;
	// Three-state strap levels
	typedef enum logic [1:0] {
		TS_STRAP_LOW = 2'b00,
		TS_STRAP_OPEN = 2'b01,
		TS_STRAP_HIGH = 2'b10
	} ts_strap_t;
endpackage : ts_pkg

// >>> ts_core_sva.sv
// Purpose: Port checker for ts_core
// Assumes: Front end answers a start after several cycles
// Notes: Bound to every ts_core instance
`timescale 1ns/1ps
module ts_chk #(
	parameter logic [7:0] PART_ID = 8'h5A
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_index_in,
	input wire logic rd_req_in,
	input wire logic ara_req_in,
	input wire logic [7:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic [7:0] ara_data_out,
	input wire logic ara_valid_out,
	input wire logic [6:0] slave_addr_out,
	input wire logic alert_oe_n_out,
	input wire logic conv_start_out
);
	logic [7:0] idx_reg;
	// Tracks the command index seen by reads
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			idx_reg <= 8'h00;
		end else if (cmd_valid_in) begin
			idx_reg <= cmd_index_in;
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	property p_rd_ans; rd_req_in |=> rd_valid_out; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_src; rd_valid_out |-> $past(rd_req_in); endproperty
	a_rd_src: assert property (p_rd_src) else $error("read answer without request");
	property p_rd_hold; !rd_valid_out && !$past(srst_in) |-> $stable(rd_data_out); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_id; rd_req_in && idx_reg == 8'hFE |=> rd_data_out == PART_ID; endproperty
	a_id: assert property (p_id) else $error("identity code wrong");
	property p_unmap; rd_req_in && idx_reg > 8'h11 && idx_reg < 8'hFE |=> rd_data_out == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_stat; rd_req_in && idx_reg == 8'h02 |=> rd_data_out[1:0] == 2'b00; endproperty
	a_stat: assert property (p_stat) else $error("status low bits set");
	property p_ara; ara_valid_out |-> $past(ara_req_in) && ara_data_out == {slave_addr_out, 1'b1};
	endproperty
	a_ara: assert property (p_ara) else $error("alert response wrong");
	property p_addr; !$past(srst_in) && !$past(srst_in, 2) |-> $stable(slave_addr_out); endproperty
	a_addr: assert property (p_addr) else $error("address changed");
	property p_por; $past(srst_in) |-> alert_oe_n_out && !conv_start_out && !rd_valid_out;
	endproperty
	a_por: assert property (p_por) else $error("outputs not idle after reset");
	property p_start; conv_start_out |=> !conv_start_out [*3]; endproperty
	a_start: assert property (p_start) else $error("start repeated");
	c_ara: cover property (ara_valid_out);
	c_alert: cover property ($fell(alert_oe_n_out));
	c_start: cover property (conv_start_out);
endmodule : ts_chk
bind ts_core ts_chk #(.PART_ID(PART_ID)) i_chk (.*);

// >>> ts_fe_model.sv
// Purpose: Conversion front end model
// Assumes: One result set per start
// Notes: Result lines carry junk outside the done cycle
`timescale 1ns/1ps
module ts_fe_model #(
	parameter int DELAY = 20
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic start_in,
	input wire logic [10:0] local_set_in,
	input wire logic [10:0] remote_set_in,
	output logic done_out,
	output logic [10:0] local_temp_out,
	output logic [10:0] remote_temp_out,
	output logic open_out
);
	int cnt;
	always @(posedge clk_sys_in) begin
		done_out <= 1'b0;
		if (srst_in) begin
			cnt <= 0;
		end else if (start_in) begin
			cnt <= DELAY;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			done_out <= (cnt == 1);
		end
	end
	// Values only valid with done
	assign local_temp_out = done_out ? local_set_in : ~local_set_in;
	assign remote_temp_out = done_out ? remote_set_in : ~remote_set_in;
	assign open_out = !done_out;
endmodule : ts_fe_model

// >>> ts_core_test.sv
// Purpose: Self-checking bench for ts_core
// Assumes: Short base period for simulation
// Notes: Reference model tracks flags and alert latch
`timescale 1ns/1ps
module ts_core_test;
	localparam logic [7:0] ID = 8'h3C; // Arbitrary value
	localparam logic [7:0] REV = 8'h07; // Arbitrary value
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic cmd_valid_in = 1'b0, cmd_has_data_in = 1'b0, rd_req_in = 1'b0, ara_req_in = 1'b0;
	logic [7:0] cmd_index_in = 8'h00, cmd_data_in = 8'h00, rd_data_out, ara_data_out;
	logic [1:0] strap_a = 2'b00, strap_b = 2'b00;
	logic conv_done_in, remote_open_in, rd_valid_out, ara_valid_out, alert_oe_n_out;
	logic conv_start_out, conv_rcancel_out, conv_extended_out;
	logic [10:0] local_temp_in, remote_temp_in, loc_set = 11'h0C8, rem_set = 11'h1A4;
	logic [6:0] slave_addr_out, abase[3] = '{7'h18, 7'h29, 7'h4C};
	logic [7:0] lim[4] = '{8'h7F, 8'hC9, 8'h7F, 8'hC9};
	logic [7:0] setup = 8'h00, rate = 8'h02, flags = 8'h00, cond = 8'h00;
	logic [7:0] idx[14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h10, 8'h11, 8'hFE, 8'hFF, 8'h12};
	logic latch = 1'b0, busy = 1'b0;
	int n_fail = 0, n_checks = 0, cyc = 0, n;
	ts_core #(.BASE_PERIOD_CYC(32'd4096), .PART_ID(ID), .PART_REV(REV)) i_dut (.*,
		.address_strap_a_in(strap_a), .address_strap_b_in(strap_b), .standby_pin_n_in(1'b1),
		.alert_o_out());
	ts_fe_model i_fe (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .start_in(conv_start_out),
		.local_set_in(loc_set), .remote_set_in(rem_set), .done_out(conv_done_in),
		.local_temp_out(local_temp_in), .remote_temp_out(remote_temp_in),
		.open_out(remote_open_in));
	initial begin
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// Model of alarm flags and latch, plus timeout
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			print_verdict();
		end
		if (conv_done_in) begin
			cond = {1'b0, $signed(loc_set[10:3]) >= $signed(lim[0]),
				$signed(loc_set[10:3]) <= $signed(lim[1]), $signed(rem_set[10:3]) >= $signed(lim[2]),
				$signed(rem_set[10:3]) <= $signed(lim[3]), 3'b000};
			flags = flags | cond;
			latch = latch | (cond != 8'h00);
		end
	end
	function automatic logic [7:0] exp_reg(input logic [7:0] i);
		logic [10:0] t;
		t = (i == 8'h10) ? rem_set : loc_set;
		case (i)
			8'h00: return loc_set[10:3];
			8'h01: return rem_set[10:3];
			8'h02: return flags | {busy, 7'h00};
			8'h03: return setup & 8'hF8;
			8'h04: return rate;
			8'h05, 8'h06, 8'h07, 8'h08: return lim[i - 8'h05];
			8'h10, 8'h11: return (rate <= 8'h04) ? {t[2:0], 5'h00} : 8'h00;
			8'hFE: return ID;
			8'hFF: return REV;
			default: return 8'h00;
		endcase
	endfunction : exp_reg
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	task automatic cmd(input logic [7:0] i, input logic d, input logic [7:0] v);
		@(negedge clk_sys_in);
		cmd_valid_in = 1'b1;
		cmd_has_data_in = d;
		cmd_index_in = i;
		cmd_data_in = v;
		@(negedge clk_sys_in);
		cmd_valid_in = 1'b0;
	endtask : cmd
	task automatic rd(input logic [7:0] i);
		cmd(i, 1'b0, 8'h00);
		rd_req_in = 1'b1;
		@(negedge clk_sys_in);
		rd_req_in = 1'b0;
		check(rd_valid_out, 1'b1);
		check(rd_data_out, exp_reg(i));
		if (i == 8'h02) begin
			flags &= cond;
			latch = latch && cond != 8'h00;
		end
	endtask : rd
	task automatic alert_chk();
		repeat (3) @(negedge clk_sys_in);
		check(alert_oe_n_out, !(latch && !setup[7]));
	endtask : alert_chk
	task automatic wait_done();
		for (int k = 0; k < 100 && conv_done_in !== 1'b1; k++)
			@(negedge clk_sys_in);
		check(conv_done_in, 1'b1);
		repeat (3) @(negedge clk_sys_in);
	endtask : wait_done
	initial begin
		void'($urandom(32'h35773664));
		strap_a = 2'($urandom % 3);
		strap_b = 2'($urandom % 3);
		repeat (3) @(negedge clk_sys_in);
		srst_in = 1'b0;
		for (int k = 0; k < 20 && !conv_start_out; k++)
			@(negedge clk_sys_in);
		n = 0;
		do begin
			@(negedge clk_sys_in);
			n++;
		end while (!conv_start_out && n < 2000);
		check(8'(n >= 1020 && n <= 1028), 8'h01);
		check(slave_addr_out, abase[strap_a] + 7'(strap_b));
		wait_done();
		foreach (idx[m]) rd(idx[m]);
		alert_chk();
		setup = 8'h40;
		cmd(8'h09, 1'b1, setup);
		for (int it = 0; it < 6; it++) begin
			for (int j = 0; j < 4; j++) begin
				lim[j] = 8'($urandom);
				cmd(8'h0B + 8'(j), 1'b1, lim[j]);
			end
			rate = 8'($urandom % 8);
			cmd(8'h0A, 1'b1, rate);
			setup = {1'($urandom), 1'b1, 6'($urandom)};
			cmd(8'h09, 1'b1, setup);
			cmd(8'h00, 1'b1, 8'hAA);
			loc_set = 11'($urandom % 1000);
			rem_set = 11'($urandom % 1000);
			cmd(8'h0F, 1'b1, 8'h00);
			busy = 1'b1;
			rd(8'h02);
			busy = 1'b0;
			wait_done();
			check(conv_extended_out, rate <= 8'h04);
			check(conv_rcancel_out, setup[4] && rate <= 8'h04);
			foreach (idx[m]) rd(idx[m]);
			alert_chk();
			@(negedge clk_sys_in);
			ara_req_in = 1'b1;
			@(negedge clk_sys_in);
			ara_req_in = 1'b0;
			check(ara_valid_out, latch);
			check(ara_data_out, latch ? {abase[strap_a] + 7'(strap_b), 1'b1} : ara_data_out);
			latch = latch && cond != 8'h00;
			alert_chk();
		end
		print_verdict();
	end
endmodule : ts_core_test
